// ---- rtl/sesfe_defines.vh ----
`ifndef SESFE_DEFINES_VH
`define SESFE_DEFINES_VH

// Clock and write cycle timing
`define SESFE_CLK_NS 50
`define SESFE_TWC_NS 5000000
`define SESFE_TMR_W 17

// Array geometry
`define SESFE_ADDR_W 10
`define SESFE_MEM_BYTES 1024
`define SESFE_PAGE_W 5
`define SESFE_PAGE_BYTES 32

// Opcodes with bit 3 removed: {op[7:4], op[2:0]}
`define SESFE_OP_SET_WL 7'h06
`define SESFE_OP_CLR_WL 7'h04
`define SESFE_OP_RD_SR 7'h05
`define SESFE_OP_WR_SR 7'h01
`define SESFE_OP_RD_ARR 7'h03
`define SESFE_OP_WR_ARR 7'h02

// Status byte fields
`define SESFE_SR_BUSY 0
`define SESFE_SR_WEL 1
`define SESFE_SR_BP_LO 2
`define SESFE_SR_BP_HI 3
`define SESFE_SR_HPE 7
`define SESFE_SR_WHILE_BUSY 8'hFF

// Protected range starts
`define SESFE_PROT_QTR 10'h300
`define SESFE_PROT_HALF 10'h200

// Synchroniser reset levels: {cs_n, sck, si, suspend_n, write_protect_n}
// Select resets low so a select held low through reset makes no false fall
`define SESFE_SYNC_RST 5'h03

`endif

// ---- rtl/sesfe_sync.v ----
`timescale 1ns/1ps
module sesfe_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// Asynchronous levels in, synchronised levels out
	input wire [WIDTH-1:0] d_in,
	output reg [WIDTH-1:0] q_out
);
	reg [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_reg <= RESET_VAL;
			q_out <= RESET_VAL;
		end else begin
			meta_reg <= d_in;
			q_out <= meta_reg;
		end
	end
endmodule // sesfe_sync

// ---- rtl/sesfe_top.v ----
`timescale 1ns/1ps
`include "sesfe_defines.vh"
module sesfe_top #(
	parameter WRITE_CYCLES = `SESFE_TWC_NS / `SESFE_CLK_NS
) (
	// Clock and power-on reset
	input wire CLK_IN,
	input wire RST_N_IN,
	// Serial pins from the master
	input wire SPI_CS_N_IN,
	input wire SPI_SCK_IN,
	input wire SPI_SI_IN,
	input wire SUSPEND_N_IN,
	input wire WRITE_PROTECT_N_IN,
	// Serial output pin, three-state as data and enable
	output reg SPI_SO_OUT,
	output reg SPI_SO_OE_OUT,
	// Device state
	output reg BUSY_OUT
);
	localparam [2:0] PH_IDLE = 3'h0;
	localparam [2:0] PH_OPC = 3'h1;
	localparam [2:0] PH_ADDR = 3'h2;
	localparam [2:0] PH_DIN = 3'h3;
	localparam [2:0] PH_DOUT = 3'h4;
	localparam [2:0] PH_IGN = 3'h5;
	localparam [31:0] WR_LAST_FULL = WRITE_CYCLES - 1;
	localparam [`SESFE_TMR_W-1:0] WR_LAST = WR_LAST_FULL[`SESFE_TMR_W-1:0];

	function [7:0] sesfe_status;
		input busy;
		input wel;
		input [1:0] bp;
		input hpe;
		begin
			if (busy)
				sesfe_status = `SESFE_SR_WHILE_BUSY;
			else
				sesfe_status = {hpe, 3'h0, bp, wel, 1'b0};
		end
	endfunction

	function sesfe_prot;
		input [1:0] bp;
		input [`SESFE_ADDR_W-1:0] addr;
		begin
			case (bp)
			2'h0: sesfe_prot = 1'b0;
			2'h1: sesfe_prot = (addr >= `SESFE_PROT_QTR);
			2'h2: sesfe_prot = (addr >= `SESFE_PROT_HALF);
			default: sesfe_prot = 1'b1;
			endcase
		end
	endfunction

	wire [4:0] sync_q;
	wire cs_n_s = sync_q[4];
	wire sck_s = sync_q[3];
	wire si_s = sync_q[2];
	wire hold_n_s = sync_q[1];
	wire wp_n_s = sync_q[0];

	sesfe_sync #(
		.WIDTH(5),
		.RESET_VAL(`SESFE_SYNC_RST)
	) u_sync (
		.clk_in(CLK_IN),
		.rst_n_in(RST_N_IN),
		.d_in({SPI_CS_N_IN, SPI_SCK_IN, SPI_SI_IN, SUSPEND_N_IN, WRITE_PROTECT_N_IN}),
		.q_out(sync_q)
	);

	reg sck_prev_reg;
	reg cs_prev_reg;
	reg active_reg;
	reg [2:0] phase_reg;
	reg [2:0] bit_cnt_reg;
	reg [6:0] in_sh_reg;
	reg [6:0] op_reg;
	reg op_done_reg;
	reg addr_byte_reg;
	reg [`SESFE_ADDR_W-1:0] addr_reg;
	reg [7:0] out_sh_reg;
	reg [2:0] out_cnt_reg;
	reg out_run_reg;
	reg wel_reg;
	reg hpe_reg;
	reg [1:0] bp_reg;
	reg [`SESFE_TMR_W-1:0] wr_cnt_reg;
	reg [7:0] sr_new_reg;
	reg sr_got_reg;
	reg wr_any_reg;
	reg wr_sr_kind_reg;
	reg [`SESFE_ADDR_W-`SESFE_PAGE_W-1:0] wr_page_reg;
	reg [`SESFE_PAGE_BYTES-1:0] mask_reg;
	reg [7:0] page_buf [0:`SESFE_PAGE_BYTES-1];
	reg [7:0] mem [0:`SESFE_MEM_BYTES-1];
	integer i;

	// Suspend gates the edges; the edge tracker keeps following SCK so no edge fakes on release
	wire live = active_reg & ~cs_n_s & hold_n_s;
	wire sck_rise = live & sck_s & ~sck_prev_reg;
	wire sck_fall = live & ~sck_s & sck_prev_reg;
	wire cs_fall = ~cs_n_s & cs_prev_reg;
	wire cs_rise = cs_n_s & ~cs_prev_reg & active_reg;
	wire [7:0] byte_in = {in_sh_reg, si_s};
	wire [6:0] op7 = {byte_in[7:4], byte_in[2:0]};
	wire hw_lock = ~wp_n_s & hpe_reg;
	wire [7:0] status = sesfe_status(BUSY_OUT, wel_reg, bp_reg, hpe_reg);
	wire [`SESFE_ADDR_W-1:0] addr_inc = addr_reg + 10'h001;

	always @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			// Select low at release is no frame start: tracker starts low
			sck_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b0;
			active_reg <= 1'b0;
			phase_reg <= PH_IDLE;
			bit_cnt_reg <= 3'h0;
			in_sh_reg <= 7'h00;
			op_reg <= 7'h00;
			op_done_reg <= 1'b0;
			addr_byte_reg <= 1'b0;
			addr_reg <= 10'h000;
			out_sh_reg <= 8'h00;
			out_cnt_reg <= 3'h0;
			out_run_reg <= 1'b0;
			wel_reg <= 1'b0;
			hpe_reg <= 1'b0;
			bp_reg <= 2'h0;
			wr_cnt_reg <= {`SESFE_TMR_W{1'b0}};
			sr_new_reg <= 8'h00;
			sr_got_reg <= 1'b0;
			wr_any_reg <= 1'b0;
			wr_sr_kind_reg <= 1'b0;
			wr_page_reg <= 5'h00;
			mask_reg <= {`SESFE_PAGE_BYTES{1'b0}};
			BUSY_OUT <= 1'b0;
			SPI_SO_OUT <= 1'b0;
			SPI_SO_OE_OUT <= 1'b0;
		end else begin
			sck_prev_reg <= sck_s;
			cs_prev_reg <= cs_n_s;
			SPI_SO_OE_OUT <= live & (phase_reg == PH_DOUT) & out_run_reg;

			if (cs_fall) begin
				active_reg <= 1'b1;
				phase_reg <= PH_OPC;
				bit_cnt_reg <= 3'h0;
				op_done_reg <= 1'b0;
				addr_byte_reg <= 1'b0;
				out_cnt_reg <= 3'h0;
				out_run_reg <= 1'b0;
				sr_got_reg <= 1'b0;
				if (!BUSY_OUT) begin
					wr_any_reg <= 1'b0;
					mask_reg <= {`SESFE_PAGE_BYTES{1'b0}};
				end
			end else if (cs_rise) begin
				active_reg <= 1'b0;
				phase_reg <= PH_IDLE;
				out_run_reg <= 1'b0;
				// Partial trailing bytes abort the command
				if (!BUSY_OUT && op_done_reg && bit_cnt_reg == 3'h0) begin
					case (op_reg)
					`SESFE_OP_SET_WL: wel_reg <= 1'b1;
					`SESFE_OP_CLR_WL: wel_reg <= 1'b0;
					`SESFE_OP_WR_SR: begin
						if (sr_got_reg && wel_reg && !hw_lock) begin
							BUSY_OUT <= 1'b1;
							wr_sr_kind_reg <= 1'b1;
							wr_cnt_reg <= {`SESFE_TMR_W{1'b0}};
						end
					end
					`SESFE_OP_WR_ARR: begin
						if (wr_any_reg && wel_reg) begin
							BUSY_OUT <= 1'b1;
							wr_sr_kind_reg <= 1'b0;
							wr_page_reg <= addr_reg[`SESFE_ADDR_W-1:`SESFE_PAGE_W];
							wr_cnt_reg <= {`SESFE_TMR_W{1'b0}};
						end
					end
					default: ;
					endcase
				end
			end else if (sck_rise) begin
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				in_sh_reg <= byte_in[6:0];
				if (bit_cnt_reg == 3'h7) begin
					case (phase_reg)
					PH_OPC: begin
						op_reg <= op7;
						op_done_reg <= 1'b1;
						if (BUSY_OUT && op7 != `SESFE_OP_RD_SR) begin
							phase_reg <= PH_IGN;
						end else begin
							case (op7)
							`SESFE_OP_RD_SR: begin
								phase_reg <= PH_DOUT;
								out_sh_reg <= status;
							end
							`SESFE_OP_WR_SR: phase_reg <= PH_DIN;
							`SESFE_OP_RD_ARR: phase_reg <= PH_ADDR;
							`SESFE_OP_WR_ARR: phase_reg <= PH_ADDR;
							default: phase_reg <= PH_IGN;
							endcase
						end
					end
					PH_ADDR: begin
						addr_byte_reg <= 1'b1;
						if (!addr_byte_reg) begin
							addr_reg[9:8] <= byte_in[1:0];
						end else begin
							addr_reg[7:0] <= byte_in;
							if (op_reg == `SESFE_OP_RD_ARR) begin
								phase_reg <= PH_DOUT;
								out_sh_reg <= mem[{addr_reg[9:8], byte_in}];
							end else begin
								phase_reg <= PH_DIN;
							end
						end
					end
					PH_DIN: begin
						if (op_reg == `SESFE_OP_WR_SR) begin
							if (!sr_got_reg)
								sr_new_reg <= byte_in;
							sr_got_reg <= 1'b1;
						end else begin
							// Low five bits wrap inside the page
							page_buf[addr_reg[4:0]] <= byte_in;
							mask_reg[addr_reg[4:0]] <= 1'b1;
							wr_any_reg <= 1'b1;
							addr_reg[4:0] <= addr_reg[4:0] + 5'h01;
						end
					end
					default: ;
					endcase
				end
			end else if (sck_fall && phase_reg == PH_DOUT) begin
				SPI_SO_OUT <= out_sh_reg[7];
				out_run_reg <= 1'b1;
				out_cnt_reg <= out_cnt_reg + 3'h1;
				if (out_cnt_reg == 3'h7) begin
					if (op_reg == `SESFE_OP_RD_SR) begin
						out_sh_reg <= status;
					end else begin
						out_sh_reg <= mem[addr_inc];
						addr_reg <= addr_inc;
					end
				end else begin
					out_sh_reg <= {out_sh_reg[6:0], 1'b0};
				end
			end

			// Self-timed write; start and finish never share a cycle
			if (BUSY_OUT) begin
				wr_cnt_reg <= wr_cnt_reg + 17'h00001;
				if (wr_cnt_reg == WR_LAST) begin
					BUSY_OUT <= 1'b0;
					wel_reg <= 1'b0;
					if (wr_sr_kind_reg) begin
						hpe_reg <= sr_new_reg[`SESFE_SR_HPE];
						bp_reg <= {sr_new_reg[`SESFE_SR_BP_HI], sr_new_reg[`SESFE_SR_BP_LO]};
					end else begin
						for (i = 0; i < `SESFE_PAGE_BYTES; i = i + 1) begin
							if (mask_reg[i] && !sesfe_prot(bp_reg, {wr_page_reg, i[4:0]}))
								mem[{wr_page_reg, i[4:0]}] <= page_buf[i];
						end
					end
				end
			end
		end
	end
endmodule // sesfe_top

// ---- test/sesfe_top_asserts.sv ----
`timescale 1ns/1ps
module sesfe_top_asserts #(
	parameter WRITE_CYCLES = 200
) (
	// Clock and reset
	input wire CLK_IN,
	input wire RST_N_IN,
	// Serial pins and busy flag
	input wire SPI_CS_N_IN,
	input wire SPI_SCK_IN,
	input wire SPI_SI_IN,
	input wire SUSPEND_N_IN,
	input wire WRITE_PROTECT_N_IN,
	input wire SPI_SO_OUT,
	input wire SPI_SO_OE_OUT,
	input wire BUSY_OUT
);
	int busy_run;
	always @(posedge CLK_IN) begin
		if (!RST_N_IN || !BUSY_OUT)
			busy_run <= 0;
		else
			busy_run <= busy_run + 1;
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	a_reset_quiet: assert property (disable iff (1'b0) !RST_N_IN |=> !SPI_SO_OE_OUT && !BUSY_OUT)
		else $error("outputs active after reset");
	a_standby_hiz: assert property (SPI_CS_N_IN [*5] |-> !SPI_SO_OE_OUT)
		else $error("output driven in standby");
	a_suspend_hiz: assert property (!SUSPEND_N_IN [*5] |-> !SPI_SO_OE_OUT)
		else $error("output driven in suspend");
	a_busy_length: assert property ($fell(BUSY_OUT) && $past(RST_N_IN) |-> busy_run == WRITE_CYCLES)
		else $error("write cycle length wrong");
	a_busy_min: assert property ($rose(BUSY_OUT) |=> BUSY_OUT [*8])
		else $error("write cycle cut short");
	a_busy_start: assert property ($rose(BUSY_OUT) |-> SPI_CS_N_IN && $past(SPI_CS_N_IN, 2))
		else $error("write cycle without select rise");
	a_so_edge: assert property ($changed(SPI_SO_OUT) && $past(RST_N_IN) |-> $past(!SPI_SCK_IN))
		else $error("output changed outside clock low");
	a_oe_start: assert property ($rose(SPI_SO_OE_OUT) |-> !SPI_CS_N_IN && SUSPEND_N_IN)
		else $error("output enabled outside a frame");
	a_oe_hold: assert property (SPI_SO_OE_OUT && !SPI_CS_N_IN && SUSPEND_N_IN |=> SPI_SO_OE_OUT)
		else $error("output dropped mid read");
	c_write: cover property ($fell(BUSY_OUT));
	c_read: cover property ($rose(SPI_SO_OE_OUT));
	c_pause: cover property (!SUSPEND_N_IN && !SPI_CS_N_IN);
endmodule // sesfe_top_asserts
bind sesfe_top sesfe_top_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
	.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_SCK_IN(SPI_SCK_IN),
	.SPI_SI_IN(SPI_SI_IN), .SUSPEND_N_IN(SUSPEND_N_IN), .WRITE_PROTECT_N_IN(WRITE_PROTECT_N_IN),
	.SPI_SO_OUT(SPI_SO_OUT), .SPI_SO_OE_OUT(SPI_SO_OE_OUT), .BUSY_OUT(BUSY_OUT));

// ---- test/sesfe_spi_master.sv ----
`timescale 1ns/1ps
module sesfe_spi_master (
	// Clock and device output
	input wire clk_in,
	input wire so_in,
	input wire so_oe_in,
	// Master pins
	output logic cs_n_out,
	output logic sck_out,
	output logic si_out,
	output logic suspend_n_out
);
	logic idle_lvl = 1'b0;
	logic last_bit = 1'b0;
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b1;
		suspend_n_out = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic go(input logic m3);
		tick(1);
		idle_lvl = m3;
		sck_out = m3;
		tick(4);
		cs_n_out = 1'b0;
		tick(4);
	endtask
	task automatic xb(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			sck_out = 1'b0;
			si_out = w[i];
			tick(4);
			// Released line floats away from the last level
			last_bit = so_oe_in ? so_in : ~last_bit;
			r[i] = last_bit;
			sck_out = 1'b1;
			tick(4);
		end
	endtask
	task automatic pause(input int n);
		sck_out = 1'b0;
		tick(4);
		suspend_n_out = 1'b0;
		tick(n);
		suspend_n_out = 1'b1;
		tick(4);
	endtask
	task automatic done();
		tick(4);
		sck_out = idle_lvl;
		tick(4);
		cs_n_out = 1'b1;
		tick(8);
	endtask
endmodule // sesfe_spi_master

// ---- test/spi_eeprom_serial_front_end_tb_top.sv ----
`timescale 1ns/1ps
module spi_eeprom_serial_front_end_tb_top;
	localparam int WC = 200;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic m3 = 1'b0;
	logic [63:0] rx = 64'h0;
	wire cs_n, sck, si, susp_n, so, so_oe, busy;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	initial forever #25 clk = ~clk;
	sesfe_spi_master m (.clk_in(clk), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n),
		.sck_out(sck), .si_out(si), .suspend_n_out(susp_n));
	sesfe_top #(.WRITE_CYCLES(WC)) dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SPI_CS_N_IN(cs_n),
		.SPI_SCK_IN(sck), .SPI_SI_IN(si), .SUSPEND_N_IN(susp_n), .WRITE_PROTECT_N_IN(wp_n),
		.SPI_SO_OUT(so), .SPI_SO_OE_OUT(so_oe), .BUSY_OUT(busy));
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Master sends only defined opcodes
	task automatic frame(input int n, input logic [63:0] tx, input int p = -1);
		logic [7:0] b;
		m.go(m3);
		for (int i = n - 1; i >= 0; i--) begin
			if (i == p)
				m.pause(40);
			m.xb(tx[8*i+:8], b);
			rx = {rx[55:0], b};
		end
		m.done();
	endtask
	task automatic wb();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 1000) begin
			@(negedge clk);
			k++;
		end
		chk("busy", {7'h00, busy}, 8'h00);
	endtask
	task automatic sr(input logic [7:0] exp);
		frame(2, 64'h0500);
		chk("status", rx[7:0], exp);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		sr(8'h00);
		frame(1, 64'h0E);
		sr(8'h02);
		frame(1, 64'h0C);
		frame(2, 64'h0D00);
		chk("status", rx[7:0], 8'h00);
		frame(1, 64'h06);
		frame(6, 64'h0AFC1EA1B2C3, 3);
		chk("busy", {7'h00, busy}, 8'h01);
		frame(1, 64'h06);
		sr(8'hFF);
		wb();
		sr(8'h00);
		m3 = 1'b1;
		frame(5, 64'h0BAC1E0000);
		chk("data", rx[15:8], 8'hA1);
		chk("data", rx[7:0], 8'hB2);
		frame(4, 64'h03000000);
		chk("data", rx[7:0], 8'hC3);
		m3 = 1'b0;
		frame(1, 64'h06);
		frame(4, 64'h0203005A);
		wb();
		frame(1, 64'h06);
		frame(2, 64'h098C);
		wb();
		sr(8'h8C);
		wp_n = 1'b0;
		frame(1, 64'h06);
		frame(2, 64'h0100);
		wb();
		sr(8'h8E);
		wp_n = 1'b1;
		frame(2, 64'h0104);
		wb();
		sr(8'h04);
		frame(4, 64'h03030000);
		chk("stored", rx[7:0], 8'h5A);
		frame(1, 64'h06);
		frame(4, 64'h02030055);
		wb();
		frame(4, 64'h03030000);
		chk("protected", rx[7:0], 8'h5A);
		frame(1, 64'h06);
		frame(4, 64'h0202FF66);
		wb();
		frame(4, 64'h0302FF00);
		chk("open", rx[7:0], 8'h66);
		m.go(m3);
		frame(0, 64'h0);
		sr(8'h04);
		frame(1, 64'h06);
		rst_n = 1'b0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		sr(8'h00);
		close_out();
	end
endmodule // spi_eeprom_serial_front_end_tb_top
